// ==== logic/ascr_pkg.sv ====
// Purpose: Shared constants and types for the converter result-capture block
// Assumes: 32-bit register bus with byte addresses
// Notes: Control and flag register layouts are local to this block
package ascr_pkg;
   // ==========================================================
   // Sizes
   localparam int NSEQ = 2;
   localparam int NCH = 12;
   localparam int CHW = 4;
   localparam int RW = 12;
   localparam int NTRG = 8;
   localparam int TSW = 3;
   localparam int PTRW = 5;

   // ==========================================================
   // Register addresses
   localparam logic [31:0] ADDR_A_CTL = 32'h4001c008;
   localparam logic [31:0] ADDR_B_CTL = 32'h4001c00c;
   localparam logic [31:0] ADDR_A_RES = 32'h4001c010;
   localparam logic [31:0] ADDR_B_RES = 32'h4001c014;
   localparam logic [31:0] ADDR_FLAGS = 32'h4001c018;

   // ==========================================================
   // Result word layout
   localparam int RES_VAL_LSB = 4;
   localparam int RES_RNG_LSB = 16;
   localparam int RES_CRS_LSB = 18;
   localparam int RES_CHN_LSB = 26;
   localparam int RES_OVR_BIT = 30;
   localparam int RES_VLD_BIT = 31;
   localparam logic [1:0] RNG_IN = 2'h0;
   localparam logic [1:0] RNG_BELOW = 2'h1;
   localparam logic [1:0] RNG_ABOVE = 2'h2;
   localparam logic [1:0] CRS_NONE = 2'h0;
   localparam logic [1:0] CRS_DOWN = 2'h2;
   localparam logic [1:0] CRS_UP = 2'h3;

   // ==========================================================
   // Sequence control layout
   localparam int CTL_CH_LSB = 0;
   localparam int CTL_TSEL_LSB = 12;
   localparam int CTL_TPOL_BIT = 18;
   localparam int CTL_INTEN_BIT = 27;
   localparam int CTL_OVREN_BIT = 28;
   localparam int CTL_MODE_BIT = 30;
   localparam int CTL_EN_BIT = 31;
   localparam logic [31:0] CTL_IMPL_MASK = 32'hd8047fff;
   localparam logic [31:0] CTL_RESET = 32'h00000000;

   // ==========================================================
   // Sequencer states
   typedef enum logic [2:0] {
      SQ_IDLE = 3'b001,
      SQ_REQ = 3'b010,
      SQ_WAIT = 3'b100
   } ascr_seq_state_t;
endpackage

// ==== logic/ascr_res_if.sv ====
// Purpose: Carrier between the sequencer and one result-word holder
// Assumes: All signals on sys_clk
// Notes: One instance per sequence
`timescale 1ns/100ps
interface ascr_res_if;
   logic load;       // End of conversion for this sequence
   logic [11:0] value;
   logic [3:0] chan;
   logic [1:0] rng;
   logic [1:0] crs;
   logic rd_clr;     // Software read of the word
   logic [31:0] word;
   modport slot (input load, value, chan, rng, crs, rd_clr, output word);
   modport user (output load, value, chan, rng, crs, rd_clr, input word);
endinterface

// ==== logic/ascr_result_slot.sv ====
// Purpose: Holds one global result word with fresh and overrun flags
// Assumes: Read and load are single-cycle strobes
// Notes: Read clears both flags; a coincident load still sets fresh
`timescale 1ns/100ps
module ascr_result_slot (
   input wire logic sys_clk,  // Peripheral clock
   input wire logic srst,     // Synchronous reset, high
   ascr_res_if.slot s         // Result word carrier
);
   logic [ascr_pkg::RW-1:0] val_r;
   logic [ascr_pkg::CHW-1:0] chan_r;
   logic [1:0] rng_r;
   logic [1:0] crs_r;
   logic vld_r;
   logic ovr_r;
   logic vld_nxt;
   logic ovr_nxt;

   // ==========================================================
   // Flag update, load sets fresh over read clear; read clear wins over overrun set
   assign vld_nxt = s.load | (vld_r & ~s.rd_clr);
   assign ovr_nxt = (s.load & vld_r & ~s.rd_clr) | (ovr_r & ~s.rd_clr);

   // Capture fields of the latest conversion
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         val_r <= '0;
         chan_r <= '0;
         rng_r <= ascr_pkg::RNG_IN;
         crs_r <= ascr_pkg::CRS_NONE;
      end else if (s.load) begin
         val_r <= s.value;
         chan_r <= s.chan;
         rng_r <= s.rng;
         crs_r <= s.crs;
      end
   end

   // Fresh and overrun flags
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         vld_r <= 1'b0;
         ovr_r <= 1'b0;
      end else begin
         vld_r <= vld_nxt;
         ovr_r <= ovr_nxt;
      end
   end

   // Word assembly, reserved bits zero
   always_comb begin
      s.word = '0;
      s.word[ascr_pkg::RES_VAL_LSB +: ascr_pkg::RW] = val_r;
      s.word[ascr_pkg::RES_RNG_LSB +: 2] = rng_r;
      s.word[ascr_pkg::RES_CRS_LSB +: 2] = crs_r;
      s.word[ascr_pkg::RES_CHN_LSB +: ascr_pkg::CHW] = chan_r;
      s.word[ascr_pkg::RES_OVR_BIT] = ovr_r;
      s.word[ascr_pkg::RES_VLD_BIT] = vld_r;
   end
endmodule

// ==== logic/ascr_top.sv ====
// Purpose: Sequence enable, trigger and result capture for a 12-bit converter
// Assumes: Converter answers each start with one conv_done pulse
// Notes: Sequence A has priority over sequence B at the converter
// Contract
// - Enable bit 31 low: sequence disabled, its triggers ignored.
// - Enable cleared mid-sequence: current conversion finishes, then sequence stops.
// - Re-enabled halted sequence waits a new trigger, resumes at next channel.
// - Enable set while trigger already active launches the sequence at once.
// - Writing 1 to the enable bit accepts triggers.
// - Separate result word per sequence holds its latest conversion.
// - Value sits in bits 15:4; bits 3:0 reserved.
// - Value is unsigned fraction of the reference span.
// - Bits 29:26 hold source channel number.
// - Fresh flag bit 31 set when a new value loads.
// - Reading the result word clears fresh and overrun flags.
// - Overrun set when a value loads while fresh still set.
// - Mode 0 with interrupt enabled: fresh flag drives sequence interrupt.
// - Mode 0 with overrun enabled: overrun flag feeds overrun interrupt.
// - Bits 17:16 give window compare against low and high thresholds.
// - Bits 19:18 give low threshold crossing versus previous channel sample.
// - Window codes: 0 in range, 1 below, 2 above, 3 reserved.
// - Crossing codes: 0 none, 2 downward, 3 upward, 1 reserved.
// - Mode 1: flag set at sequence end; overrun flag not forwarded.
`timescale 1ns/100ps
module ascr_top (
   input wire logic sys_clk,                          // Peripheral clock
   input wire logic srst,                             // Synchronous reset
   input wire logic [31:0] bus_addr,                  // Register byte address
   input wire logic [31:0] bus_wdata,                 // Write data
   input wire logic bus_wr,                           // Write strobe
   input wire logic bus_rd,                           // Read strobe
   output logic [31:0] bus_rdata,                     // Read data, next cycle
   input wire logic [ascr_pkg::NTRG-1:0] trig_in,     // Trigger inputs
   input wire logic [ascr_pkg::RW-1:0] low_threshold, // Window low bound
   input wire logic [ascr_pkg::RW-1:0] high_threshold,// Window high bound
   output logic conv_start,                           // Start pulse to converter
   output logic [ascr_pkg::CHW-1:0] conv_channel,     // Channel to convert
   input wire logic conv_done,                        // Conversion finished
   input wire logic [ascr_pkg::RW-1:0] conv_value,    // Converted value
   output logic [ascr_pkg::NSEQ-1:0] seq_int,         // Per-sequence interrupt
   output logic ovr_int                               // Overrun interrupt
);
   // ==========================================================
   // Helper: first enabled channel at or above a start index
   function automatic logic [ascr_pkg::PTRW-1:0] next_chan(
      input logic [ascr_pkg::NCH-1:0] mask,
      input logic [ascr_pkg::PTRW-1:0] lo
   );
      logic [ascr_pkg::PTRW-1:0] res;
      res = '0;
      for (int i = ascr_pkg::NCH - 1; i >= 0; i--) begin
         if (mask[i] && (i >= int'(lo))) begin
            res = {1'b1, i[ascr_pkg::CHW-1:0]};
         end
      end
      return res;
   endfunction

   // ==========================================================
   // Shared state
   logic [31:0] ctl_r [ascr_pkg::NSEQ];
   logic [ascr_pkg::NSEQ-1:0] eos_flag_r;
   logic [ascr_pkg::NSEQ-1:0] eos_pulse;
   logic [ascr_pkg::NSEQ-1:0] req;
   logic [ascr_pkg::NSEQ-1:0] grant;
   logic [ascr_pkg::NSEQ-1:0] rd_res;
   logic [ascr_pkg::NSEQ-1:0] wr_ctl;
   logic [ascr_pkg::NSEQ-1:0] vld;
   logic [ascr_pkg::NSEQ-1:0] ovr;
   logic [ascr_pkg::NSEQ-1:0] mode;
   logic [31:0] res_word [ascr_pkg::NSEQ];
   logic [ascr_pkg::CHW-1:0] cur_ch [ascr_pkg::NSEQ];
   logic busy_r;
   logic owner_r;
   logic conv_start_r;
   logic [ascr_pkg::CHW-1:0] conv_channel_r;
   logic [31:0] bus_rdata_r;
   logic [31:0] rd_mux;
   logic wr_flags;
   logic [ascr_pkg::NCH-1:0] above_r;
   logic [ascr_pkg::NCH-1:0] seen_r;
   logic [1:0] rng_now;
   logic [1:0] crs_now;
   logic above_now;
   logic done_ok;

   // ==========================================================
   // Register bus decode
   assign wr_flags = bus_wr & (bus_addr == ascr_pkg::ADDR_FLAGS);
   assign wr_ctl[0] = bus_wr & (bus_addr == ascr_pkg::ADDR_A_CTL);
   assign wr_ctl[1] = bus_wr & (bus_addr == ascr_pkg::ADDR_B_CTL);
   assign rd_res[0] = bus_rd & (bus_addr == ascr_pkg::ADDR_A_RES);
   assign rd_res[1] = bus_rd & (bus_addr == ascr_pkg::ADDR_B_RES);

   // Read mux; result words are read-only, unmapped reads zero
   always_comb begin
      rd_mux = '0;
      case (bus_addr)
         ascr_pkg::ADDR_A_CTL: rd_mux = ctl_r[0];
         ascr_pkg::ADDR_B_CTL: rd_mux = ctl_r[1];
         ascr_pkg::ADDR_A_RES: rd_mux = res_word[0];
         ascr_pkg::ADDR_B_RES: rd_mux = res_word[1];
         ascr_pkg::ADDR_FLAGS: rd_mux = {{(32-ascr_pkg::NSEQ){1'b0}}, eos_flag_r};
         default: rd_mux = '0;
      endcase
   end

   // Read data register, valid only the cycle after the strobe
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         bus_rdata_r <= '0;
      end else begin
         bus_rdata_r <= bus_rd ? rd_mux : '0;
      end
   end
   assign bus_rdata = bus_rdata_r;

   // ==========================================================
   // Converter arbitration, sequence A first
   assign grant[0] = req[0] & ~busy_r;
   assign grant[1] = req[1] & ~busy_r & ~req[0];
   assign done_ok = conv_done & busy_r;

   // Converter handshake registers
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         busy_r <= 1'b0;
         owner_r <= 1'b0;
         conv_start_r <= 1'b0;
         conv_channel_r <= '0;
      end else begin
         conv_start_r <= |grant;
         if (|grant) begin
            busy_r <= 1'b1;
            owner_r <= grant[1];
            conv_channel_r <= grant[1] ? cur_ch[1] : cur_ch[0];
         end else if (done_ok) begin
            busy_r <= 1'b0;
         end
      end
   end
   assign conv_start = conv_start_r;
   assign conv_channel = conv_channel_r;

   // ==========================================================
   // Threshold window and crossing of the low bound
   assign above_now = (conv_value >= low_threshold);
   assign rng_now = (conv_value < low_threshold) ? ascr_pkg::RNG_BELOW :
                    (conv_value > high_threshold) ? ascr_pkg::RNG_ABOVE :
                    ascr_pkg::RNG_IN;
   assign crs_now = (!seen_r[conv_channel_r] ||
                     (above_r[conv_channel_r] == above_now)) ? ascr_pkg::CRS_NONE :
                    above_now ? ascr_pkg::CRS_UP : ascr_pkg::CRS_DOWN;

   // Per-channel previous side of the low bound
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         above_r <= '0;
         seen_r <= '0;
      end else if (done_ok) begin
         above_r[conv_channel_r] <= above_now;
         seen_r[conv_channel_r] <= 1'b1;
      end
   end

   // ==========================================================
   // Per-sequence sequencer, control and result word
   for (genvar g = 0; g < ascr_pkg::NSEQ; g++) begin : g_seq
      ascr_res_if rif ();
      ascr_pkg::ascr_seq_state_t st_r;
      logic [ascr_pkg::CHW-1:0] cur_r;
      logic resume_r;
      logic trig_prev_r;
      logic en;
      logic act;
      logic fire;
      logic mine;
      logic [ascr_pkg::NCH-1:0] mask;
      logic [ascr_pkg::TSW-1:0] tsel;
      logic [ascr_pkg::PTRW-1:0] first;
      logic [ascr_pkg::PTRW-1:0] after;

      // Control fields
      assign en = ctl_r[g][ascr_pkg::CTL_EN_BIT];
      assign mode[g] = ctl_r[g][ascr_pkg::CTL_MODE_BIT];
      assign mask = ctl_r[g][ascr_pkg::CTL_CH_LSB +: ascr_pkg::NCH];
      assign tsel = ctl_r[g][ascr_pkg::CTL_TSEL_LSB +: ascr_pkg::TSW];
      assign act = trig_in[tsel] ~^ ctl_r[g][ascr_pkg::CTL_TPOL_BIT];

      // Launch on entry to active level; disabled history counts inactive
      assign fire = en & act & ~trig_prev_r;
      assign first = next_chan(mask, '0);
      assign after = next_chan(mask, ascr_pkg::PTRW'({1'b0, cur_r} + 5'h01));
      assign mine = done_ok & (owner_r == g[0]);
      assign req[g] = (st_r == ascr_pkg::SQ_REQ) & en;
      assign cur_ch[g] = cur_r;
      assign eos_pulse[g] = mine & (st_r == ascr_pkg::SQ_WAIT) &
                            ~after[ascr_pkg::CHW];

      // Control register write
      always_ff @(posedge sys_clk) begin
         if (srst) begin
            ctl_r[g] <= ascr_pkg::CTL_RESET;
         end else if (wr_ctl[g]) begin
            ctl_r[g] <= bus_wdata & ascr_pkg::CTL_IMPL_MASK;
         end
      end

      // Trigger history
      always_ff @(posedge sys_clk) begin
         if (srst) begin
            trig_prev_r <= 1'b0;
         end else begin
            trig_prev_r <= en & act;
         end
      end

      // Sequencer
      always_ff @(posedge sys_clk) begin
         if (srst) begin
            st_r <= ascr_pkg::SQ_IDLE;
            cur_r <= '0;
            resume_r <= 1'b0;
         end else begin
            case (st_r)
               ascr_pkg::SQ_IDLE: begin
                  if (fire && resume_r) begin
                     st_r <= ascr_pkg::SQ_REQ;
                     resume_r <= 1'b0;
                  end else if (fire && first[ascr_pkg::CHW]) begin
                     st_r <= ascr_pkg::SQ_REQ;
                     cur_r <= first[ascr_pkg::CHW-1:0];
                  end
               end
               ascr_pkg::SQ_REQ: begin
                  if (!en) begin
                     st_r <= ascr_pkg::SQ_IDLE;
                     resume_r <= 1'b1;
                  end else if (grant[g]) begin
                     st_r <= ascr_pkg::SQ_WAIT;
                  end
               end
               ascr_pkg::SQ_WAIT: begin
                  if (mine) begin
                     if (after[ascr_pkg::CHW]) begin
                        cur_r <= after[ascr_pkg::CHW-1:0];
                        st_r <= en ? ascr_pkg::SQ_REQ : ascr_pkg::SQ_IDLE;
                        resume_r <= ~en;
                     end else begin
                        st_r <= ascr_pkg::SQ_IDLE;
                        resume_r <= 1'b0;
                     end
                  end
               end
               default: st_r <= ascr_pkg::SQ_IDLE;
            endcase
         end
      end

      // Result word feed
      assign rif.load = mine;
      assign rif.value = conv_value;
      assign rif.chan = conv_channel_r;
      assign rif.rng = rng_now;
      assign rif.crs = crs_now;
      assign rif.rd_clr = rd_res[g];
      assign res_word[g] = rif.word;
      assign vld[g] = rif.word[ascr_pkg::RES_VLD_BIT];
      assign ovr[g] = rif.word[ascr_pkg::RES_OVR_BIT];

      // Result word holder
      ascr_result_slot u_slot (
         .sys_clk(sys_clk),
         .srst(srst),
         .s(rif.slot)
      );

      // Interrupt request per sequence
      assign seq_int[g] = ctl_r[g][ascr_pkg::CTL_INTEN_BIT] &
                          (mode[g] ? eos_flag_r[g] : vld[g]);
   end

   // ==========================================================
   // End-of-sequence flags, write one to clear, set wins
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         eos_flag_r <= '0;
      end else begin
         eos_flag_r <= (eos_pulse & mode) |
                       (eos_flag_r & ~(wr_flags ? bus_wdata[ascr_pkg::NSEQ-1:0] : '0));
      end
   end

   // Overrun request, only sequences in per-conversion mode
   assign ovr_int = |(ovr & ~mode &
                      {ctl_r[1][ascr_pkg::CTL_OVREN_BIT],
                       ctl_r[0][ascr_pkg::CTL_OVREN_BIT]});
endmodule

// ==== verif/ascr_conv_model.sv ====
// Purpose: Converter model answering start pulses
// Assumes: One conversion at a time
// Notes: Value line shows the inverse outside the done cycle
`timescale 1ns/100ps
module ascr_conv_model (
   input wire logic sys_clk,         // Peripheral clock
   input wire logic srst,            // Synchronous reset
   input wire logic conv_start,      // Start pulse
   input wire logic [7:0] lat,       // Start to done cycles
   input wire logic [11:0] next_val, // Value to return
   output logic conv_done,           // Done pulse
   output logic [11:0] conv_value    // Converted value
);
   logic [7:0] cnt_r;
   logic [11:0] hold_r;
   // ====================
   // Countdown, done pulse and value
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         cnt_r <= 8'h0;
         hold_r <= 12'h0;
         conv_done <= 1'h0;
         conv_value <= 12'hfff;
      end else begin
         conv_done <= cnt_r == 8'h1;
         conv_value <= cnt_r == 8'h1 ? hold_r : ~hold_r;
         if (conv_start) begin
            cnt_r <= lat;
            hold_r <= next_val;
         end else if (cnt_r != 8'h0)
            cnt_r <= cnt_r - 8'h1;
      end
   end
endmodule

// ==== verif/ascr_top_props.sv ====
// Purpose: Port-level checks for the converter result-capture block
// Assumes: Control words change only through bus writes
// Notes: Shadows both control words to know mode and enable
`timescale 1ns/100ps
module ascr_top_props (
   input wire logic sys_clk,          // Peripheral clock
   input wire logic srst,             // Synchronous reset
   input wire logic [31:0] bus_addr,  // Register address
   input wire logic [31:0] bus_wdata, // Write data
   input wire logic bus_wr,           // Write strobe
   input wire logic bus_rd,           // Read strobe
   input wire logic [31:0] bus_rdata, // Read data
   input wire logic conv_start,       // Start pulse
   input wire logic conv_done,        // Conversion finished
   input wire logic [ascr_pkg::NSEQ-1:0] seq_int, // Sequence interrupts
   input wire logic ovr_int           // Overrun interrupt
);
   logic [31:0] ctl_a_r, ctl_b_r;
   logic [1:0] off_cnt_r;
   logic rd_res_r;
   // ====================
   // Shadow decode
   wire wr_a = bus_wr && bus_addr == ascr_pkg::ADDR_A_CTL;
   wire wr_b = bus_wr && bus_addr == ascr_pkg::ADDR_B_CTL;
   wire both_off = !ctl_a_r[31] && !ctl_b_r[31];
   wire rd_res = bus_rd && (bus_addr == ascr_pkg::ADDR_A_RES || bus_addr == ascr_pkg::ADDR_B_RES);
   // Control shadows, disabled time, result read marker
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ctl_a_r <= 32'h0;
         ctl_b_r <= 32'h0;
         off_cnt_r <= 2'h0;
         rd_res_r <= 1'h0;
      end else begin
         if (wr_a)
            ctl_a_r <= bus_wdata;
         if (wr_b)
            ctl_b_r <= bus_wdata;
         off_cnt_r <= both_off ? off_cnt_r + {1'h0, off_cnt_r != 2'h3} : 2'h0;
         rd_res_r <= rd_res;
      end
   end
   // ====================
   // Properties
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (srst);
   a_rsv_zero:
      assert property (rd_res_r |-> bus_rdata[3:0] == 4'h0 && bus_rdata[25:20] == 6'h0)
      else $error("Reserved result bits not zero");
   a_codes_legal:
      assert property (rd_res_r |-> bus_rdata[17:16] != 2'h3 && bus_rdata[19:18] != 2'h1)
      else $error("Reserved compare code seen");
   a_start_gap:
      assert property (conv_done |=> !conv_start)
      else $error("Start right after done");
   a_quiet_off:
      assert property (off_cnt_r == 2'h3 |-> !conv_start)
      else $error("Start while both sequences disabled");
   a_int_a_cause:
      assert property ($rose(seq_int[0]) && !$past(bus_wr) |-> $past(conv_done))
      else $error("Sequence A interrupt without conversion");
   a_ovr_cause:
      assert property ($rose(ovr_int) && !$past(bus_wr) |-> $past(conv_done))
      else $error("Overrun interrupt without conversion");
   a_mode1_no_ovr:
      assert property (ctl_a_r[30] && ctl_b_r[30] |-> !ovr_int)
      else $error("Overrun forwarded in end-of-sequence mode");
   a_rd_clears:
      assert property (bus_rd && bus_addr == ascr_pkg::ADDR_A_RES && !conv_done
         && !ctl_a_r[30] |=> !seq_int[0])
      else $error("Read left sequence A interrupt set");
endmodule

bind ascr_top ascr_top_props u_props (
   .sys_clk(sys_clk), .srst(srst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
   .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .conv_start(conv_start),
   .conv_done(conv_done), .seq_int(seq_int), .ovr_int(ovr_int)
);

// ==== verif/ascr_top_test.sv ====
// Purpose: Self-checking bench for the converter result-capture block
// Assumes: Converter model answers each start after lat cycles
// Notes: Read data compared by a watcher fed from a queue
`timescale 1ns/100ps
module ascr_top_test;
   logic sys_clk, srst, bus_wr, bus_rd, rd_q, conv_start, conv_done, ovr_int;
   logic [31:0] bus_addr, bus_wdata, bus_rdata, n_st, s0, cyc;
   logic [11:0] lo_th, hi_th, conv_value, next_val, v;
   logic [7:0] trig_in, lat;
   logic [3:0] conv_channel;
   logic [1:0] seq_int;
   logic [31:0] exp_q[$];
   int mismatches, n_compared, i;
   logic [11:0] tv [6] = '{12'h032, 12'h096, 12'h0fa, 12'h014, 12'hfff, 12'h000};
   logic [1:0] tc [6] = '{2'h0, 2'h3, 2'h0, 2'h2, 2'h3, 2'h2};
   // ====================
   // Design and converter
   ascr_top dut (.sys_clk(sys_clk), .srst(srst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .trig_in(trig_in),
      .low_threshold(lo_th), .high_threshold(hi_th), .conv_start(conv_start),
      .conv_channel(conv_channel), .conv_done(conv_done), .conv_value(conv_value),
      .seq_int(seq_int), .ovr_int(ovr_int));
   ascr_conv_model u_conv (.sys_clk(sys_clk), .srst(srst), .conv_start(conv_start),
      .lat(lat), .next_val(next_val), .conv_done(conv_done), .conv_value(conv_value));
   // ====================
   // Helpers
   function automatic logic [31:0] ctl(input logic en, input logic md, input logic [2:0] ts,
      input logic [11:0] m);
      return {en, md, 1'h0, 2'h3, 8'h0, 1'h1, 3'h0, ts, m};
   endfunction
   function automatic logic [31:0] word(input logic [11:0] x, input logic [3:0] ch,
      input logic ov, input logic vl, input logic [1:0] cr);
      logic [1:0] rg;
      rg = x < lo_th ? 2'h1 : (x > hi_th ? 2'h2 : 2'h0);
      return {vl, ov, ch, 6'h0, cr, rg, x, 4'h0};
   endfunction
   task chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task chk_bit(input string nm, input logic e, input logic g);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %s expected %b seen %b", nm, e, g);
      end
   endtask
   task wr(input logic [31:0] a, input logic [31:0] d);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'h1;
      @(posedge sys_clk);
      bus_wr <= 1'h0;
      @(posedge sys_clk);
   endtask
   task rd(input logic [31:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus_addr <= a;
      bus_rd <= 1'h1;
      @(posedge sys_clk);
      bus_rd <= 1'h0;
      @(posedge sys_clk);
   endtask
   task pulse(input int k);
      trig_in[k] <= 1'h1;
      @(posedge sys_clk);
      trig_in[k] <= 1'h0;
      @(posedge sys_clk);
   endtask
   task wait_done(input int k);
      int n;
      repeat (k) begin
         n = 0;
         do begin
            @(posedge sys_clk);
            n++;
         end while (conv_done !== 1'h1 && n < 100);
         chk_bit("conv_done", 1'h1, conv_done);
      end
      @(posedge sys_clk);
   endtask
   task complete_run();
      if (mismatches == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // ====================
   // Clock, cycle limit, start count, read watcher
   always #20 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc <= srst ? 32'h0 : cyc + 32'h1;
      if (srst)
         n_st <= 32'h0;
      else if (conv_start === 1'h1)
         n_st <= n_st + 32'h1;
      if (rd_q)
         chk_word("rdata", exp_q.pop_front(), bus_rdata);
      rd_q <= bus_rd;
      if (cyc == 32'h1388) begin
         mismatches++;
         complete_run();
      end
   end
   // ====================
   // Main sequence
   initial begin
      sys_clk = 1'h0;
      srst = 1'h1;
      {bus_addr, bus_wdata, bus_wr, bus_rd, trig_in} = '0;
      next_val = '0;
      lo_th = 12'h064;
      hi_th = 12'h0c8;
      lat = 8'h02;
      mismatches = 0;
      n_compared = 0;
      void'($urandom(32'hdc9c));
      repeat (4) @(posedge sys_clk);
      srst <= 1'h0;
      @(posedge sys_clk);
      rd(ascr_pkg::ADDR_A_RES, 32'h0);
      rd(32'h4001c01c, 32'h0);
      rd(ascr_pkg::ADDR_A_CTL, 32'h0);
      wr(ascr_pkg::ADDR_B_CTL, ctl(1'h0, 1'h0, 3'h1, 12'h008));
      s0 = n_st;
      pulse(1);
      repeat (20) @(posedge sys_clk);
      chk_word("starts", s0, n_st);
      next_val <= 12'($urandom);
      trig_in[1] <= 1'h1;
      wr(ascr_pkg::ADDR_B_CTL, ctl(1'h1, 1'h0, 3'h1, 12'h008));
      wait_done(1);
      v = next_val;
      trig_in[1] <= 1'h0;
      chk_bit("seq_int_b", 1'h1, seq_int[1]);
      rd(ascr_pkg::ADDR_B_RES, word(v, 4'h3, 1'h0, 1'h1, 2'h0));
      chk_bit("seq_int_b", 1'h0, seq_int[1]);
      rd(ascr_pkg::ADDR_B_RES, word(v, 4'h3, 1'h0, 1'h0, 2'h0));
      rd(ascr_pkg::ADDR_A_RES, 32'h0);
      rd(ascr_pkg::ADDR_B_CTL, ctl(1'h1, 1'h0, 3'h1, 12'h008));
      next_val <= 12'($urandom);
      wr(ascr_pkg::ADDR_A_CTL, ctl(1'h1, 1'h0, 3'h0, 12'h006));
      pulse(0);
      wait_done(2);
      v = next_val;
      chk_bit("seq_int_a", 1'h1, seq_int[0]);
      chk_bit("ovr_int", 1'h1, ovr_int);
      rd(ascr_pkg::ADDR_A_RES, word(v, 4'h2, 1'h1, 1'h1, 2'h0));
      chk_bit("ovr_int", 1'h0, ovr_int);
      rd(ascr_pkg::ADDR_A_RES, word(v, 4'h2, 1'h0, 1'h0, 2'h0));
      wr(ascr_pkg::ADDR_A_CTL, ctl(1'h1, 1'h0, 3'h0, 12'h001));
      for (i = 0; i < 6; i++) begin
         next_val <= tv[i];
         pulse(0);
         wait_done(1);
         rd(ascr_pkg::ADDR_A_RES, word(tv[i], 4'h0, 1'h0, 1'h1, tc[i]));
      end
      // Slow conversion finishes, sequence halted by clearing the enable mid-flight
      lat <= 8'h0c;
      next_val <= 12'($urandom);
      wr(ascr_pkg::ADDR_A_CTL, ctl(1'h1, 1'h0, 3'h0, 12'h030));
      pulse(0);
      for (i = 0; i < 50 && conv_start !== 1'h1; i++)
         @(posedge sys_clk);
      chk_word("conv_channel", 32'h4, {28'h0, conv_channel});
      wr(ascr_pkg::ADDR_A_CTL, ctl(1'h0, 1'h0, 3'h0, 12'h030));
      wait_done(1);
      v = next_val;
      s0 = n_st;
      repeat (20) @(posedge sys_clk);
      chk_word("starts", s0, n_st);
      rd(ascr_pkg::ADDR_A_RES, word(v, 4'h4, 1'h0, 1'h1, 2'h0));
      wr(ascr_pkg::ADDR_A_CTL, ctl(1'h1, 1'h0, 3'h0, 12'h030));
      repeat (20) @(posedge sys_clk);
      chk_word("starts", s0, n_st);
      pulse(0);
      wait_done(1);
      rd(ascr_pkg::ADDR_A_RES, word(v, 4'h5, 1'h0, 1'h1, 2'h0));
      chk_word("starts", s0 + 32'h1, n_st);
      // End-of-sequence mode on both sequences
      lat <= 8'h02;
      next_val <= 12'($urandom);
      wr(ascr_pkg::ADDR_B_CTL, ctl(1'h1, 1'h1, 3'h1, 12'h008));
      wr(ascr_pkg::ADDR_A_CTL, ctl(1'h1, 1'h1, 3'h0, 12'h180));
      pulse(0);
      wait_done(2);
      v = next_val;
      chk_bit("ovr_int", 1'h0, ovr_int);
      chk_bit("seq_int_a", 1'h1, seq_int[0]);
      rd(ascr_pkg::ADDR_FLAGS, 32'h1);
      wr(ascr_pkg::ADDR_FLAGS, 32'h1);
      rd(ascr_pkg::ADDR_FLAGS, 32'h0);
      rd(ascr_pkg::ADDR_A_RES, word(v, 4'h8, 1'h1, 1'h1, 2'h0));
      wr(ascr_pkg::ADDR_A_RES, 32'hffffffff);
      rd(ascr_pkg::ADDR_A_RES, word(v, 4'h8, 1'h0, 1'h0, 2'h0));
      // Active-low trigger already active at enable
      wr(ascr_pkg::ADDR_B_CTL, ctl(1'h1, 1'h0, 3'h1, 12'h008) & 32'hfffbffff);
      wait_done(1);
      chk_bit("seq_int_b", 1'h1, seq_int[1]);
      repeat (3) @(posedge sys_clk);
      complete_run();
   end
endmodule
